// >>> dcf_fifo.sv
`timescale 1ns/100ps
`include "dcf_params.svh"
module dcf_fifo #(
  parameter int DEPTH = `DCF_DEPTH_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic WR_CLK_PIN,
  input wire logic WR_EN_N,
  input wire logic [17:0] WR_DATA,
  input wire logic RD_CLK_PIN,
  input wire logic RD_EN_N,
  input wire logic OUT_EN_N,
  output logic [17:0] RD_DATA,
  output logic RD_DATA_OE,
  input wire logic REPLAY_STROBE,
  output logic EMPTY_N,
  output logic FULL_N,
  output logic HALF_FULL_N,
  output logic ALMOST_EMPTY_N,
  output logic ALMOST_FULL_N,
  input wire logic FIRST_IN_CHAIN,
  input wire logic WR_CHAIN_IN,
  input wire logic RD_CHAIN_IN,
  output logic WR_CHAIN_OUT,
  output logic RD_CHAIN_OUT
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_CNT = PW'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_ADR = AW'(DEPTH - 1);

  generate
    if (DEPTH < 16 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("dcf_fifo: DEPTH must be a power of two from 16 to 65536");
    end
  endgenerate

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
    end
    from_gray = b;
  endfunction : from_gray

  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    merge_sel = r;
  endfunction : merge_sel

  // pins from outside the system clock
  logic [`DCF_PINS-1:0] pin_raw;
  logic [`DCF_PINS-1:0] pin_lvl;
  logic [`DCF_PINS-1:0] pin_chg;

  assign pin_raw = {WR_DATA, RD_CHAIN_IN, WR_CHAIN_IN, FIRST_IN_CHAIN,
                    REPLAY_STROBE, OUT_EN_N, RD_EN_N, WR_EN_N,
                    RD_CLK_PIN, WR_CLK_PIN};

  dcf_pin_sync #(
    .W(`DCF_PINS),
    .RESET_VAL(`DCF_PIN_RESET)
  ) u_pins (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .raw(pin_raw),
    .level(pin_lvl),
    .change(pin_chg)
  );

  logic wclk_rise;
  logic rclk_rise;
  logic replay_rise;
  dcf_pkg::dcf_word_t wr_word;
  assign wclk_rise = pin_chg[`DCF_P_WCLK] & (pin_lvl[`DCF_P_WCLK] == 1'b0);
  assign rclk_rise = pin_chg[`DCF_P_RCLK] & (pin_lvl[`DCF_P_RCLK] == 1'b0);
  assign replay_rise = pin_chg[`DCF_P_RT] & pin_lvl[`DCF_P_RT] == 1'b0;
  assign wr_word = pin_lvl[`DCF_P_D +: 18];

  // register file
  logic [15:0] ae_off_reg, ae_off_next;
  logic [15:0] af_off_reg, af_off_next;
  logic cascade_reg, cascade_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  // init counter, chain strap is read one cycle before the pin pipeline has filled
  logic [2:0] init_reg, init_next;
  logic load_tok;

  // write side
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] wr_gray_reg;
  logic [PW-1:0] rg_s1_reg, rg_s2_reg;
  logic [PW-1:0] wcnt_reg, wcnt_next;
  logic wr_tok_reg, wr_tok_next;
  logic wxo_reg, wxo_next;
  logic full_n_next, hf_n_next, af_n_next;
  logic wr_ok;

  // read side
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [PW-1:0] rd_gray_reg;
  logic [PW-1:0] wg_s1_reg, wg_s2_reg;
  logic [PW-1:0] rcnt_next;
  logic rd_tok_reg, rd_tok_next;
  logic rxo_reg, rxo_next;
  logic empty_n_next, ae_n_next;
  logic oe_reg, oe_next;
  dcf_pkg::dcf_word_t rd_data_reg, rd_data_next;
  logic rd_ok;

  dcf_pkg::dcf_flags_s flags_reg;
  dcf_pkg::dcf_word_t mem [DEPTH];

  always_comb begin
    init_next = init_reg;
    if (init_reg != `DCF_INIT_CYCLES) begin
      init_next = init_reg + 3'h1;
    end
  end
  assign load_tok = (init_reg == `DCF_INIT_CYCLES - 3'h1);

  always_comb begin
    ae_off_next = ae_off_reg;
    af_off_next = af_off_reg;
    cascade_next = cascade_reg;
    dat_next = 32'h00000000;
    ack_next = WB_CYC_I & WB_STB_I & ~ack_reg;
    // a write lands at the edge where the master samples ack high
    if (ack_reg && WB_CYC_I && WB_STB_I && WB_WE_I) begin
      case (WB_ADR_I)
        `DCF_ADR_AE_OFF: ae_off_next = 16'(merge_sel({16'h0000, ae_off_reg},
                                                     WB_DAT_I, WB_SEL_I));
        `DCF_ADR_AF_OFF: af_off_next = 16'(merge_sel({16'h0000, af_off_reg},
                                                     WB_DAT_I, WB_SEL_I));
        `DCF_ADR_CONFIG: if (WB_SEL_I[0]) begin
          cascade_next = WB_DAT_I[`DCF_CFG_CASCADE];
        end
        default: ;
      endcase
    end else if (ack_next && !WB_WE_I) begin
      case (WB_ADR_I)
        `DCF_ADR_AE_OFF: dat_next = {16'h0000, ae_off_reg};
        `DCF_ADR_AF_OFF: dat_next = {16'h0000, af_off_reg};
        `DCF_ADR_STATUS: dat_next = {25'h0000000, rd_tok_reg, wr_tok_reg,
                                     flags_reg.almost_full_n,
                                     flags_reg.almost_empty_n,
                                     flags_reg.half_full_n,
                                     flags_reg.full_n, flags_reg.empty_n};
        `DCF_ADR_COUNT: dat_next = 32'(wcnt_reg);
        `DCF_ADR_CONFIG: dat_next = {31'h00000000, cascade_reg};
        default: dat_next = 32'h00000000;
      endcase
    end
  end

  // write side: tokens pass around the ring as toggles on the chain pins
  always_comb begin
    wr_ok = wclk_rise & ~pin_lvl[`DCF_P_WEN] & flags_reg.full_n;
    wr_ok = wr_ok & (wr_tok_reg | ~cascade_reg);
    wr_ptr_next = wr_ptr_reg + (wr_ok ? PW'(1) : PW'(0));
    wr_tok_next = wr_tok_reg;
    wxo_next = wxo_reg;
    if (load_tok) begin
      wr_tok_next = ~pin_lvl[`DCF_P_FL];
    end else if (cascade_reg && wr_ok && wr_ptr_reg[AW-1:0] == LAST_ADR) begin
      wr_tok_next = 1'b0;
      wxo_next = ~wxo_reg;
    end else if (pin_chg[`DCF_P_WXI]) begin
      wr_tok_next = 1'b1;
    end
    // count against the synchronised read pointer, so room is never overstated
    wcnt_next = wr_ptr_next - from_gray(rg_s2_reg);
    full_n_next = wcnt_next != FULL_CNT;
    hf_n_next = wcnt_next <= HALF_CNT;
    af_n_next = wcnt_next < FULL_CNT - PW'(af_off_reg);
  end

  // read side
  always_comb begin
    rd_ok = rclk_rise & ~pin_lvl[`DCF_P_REN] & flags_reg.empty_n;
    rd_ok = rd_ok & (rd_tok_reg | ~cascade_reg);
    rd_ptr_next = rd_ptr_reg + (rd_ok ? PW'(1) : PW'(0));
    rd_data_next = rd_data_reg;
    if (rd_ok) begin
      rd_data_next = mem[rd_ptr_reg[AW-1:0]];
    end
    // replay restarts reading at the first word after reset, standalone only
    if (replay_rise && !cascade_reg) begin
      rd_ptr_next = '0;
    end
    rd_tok_next = rd_tok_reg;
    rxo_next = rxo_reg;
    if (load_tok) begin
      rd_tok_next = ~pin_lvl[`DCF_P_FL];
    end else if (cascade_reg && rd_ok && rd_ptr_reg[AW-1:0] == LAST_ADR) begin
      rd_tok_next = 1'b0;
      rxo_next = ~rxo_reg;
    end else if (pin_chg[`DCF_P_RXI]) begin
      rd_tok_next = 1'b1;
    end
    rcnt_next = from_gray(wg_s2_reg) - rd_ptr_next;
    empty_n_next = rcnt_next != PW'(0);
    ae_n_next = rcnt_next > PW'(ae_off_reg);
    oe_next = ~pin_lvl[`DCF_P_OE];
  end

  always_ff @(posedge SYS_CLK) begin
    if (wr_ok) begin
      mem[wr_ptr_reg[AW-1:0]] <= wr_word;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ae_off_reg <= `DCF_AE_RESET;
      af_off_reg <= `DCF_AF_RESET;
      cascade_reg <= `DCF_CFG_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      init_reg <= 3'h0;
    end else begin
      ae_off_reg <= ae_off_next;
      af_off_reg <= af_off_next;
      cascade_reg <= cascade_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      init_reg <= init_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= '0;
      wr_gray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
      wcnt_reg <= '0;
      wr_tok_reg <= 1'b0;
      wxo_reg <= 1'b0;
      flags_reg.full_n <= 1'b1;
      flags_reg.half_full_n <= 1'b1;
      flags_reg.almost_full_n <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      wr_gray_reg <= to_gray(wr_ptr_next);
      rg_s1_reg <= rd_gray_reg;
      rg_s2_reg <= rg_s1_reg;
      wcnt_reg <= wcnt_next;
      wr_tok_reg <= wr_tok_next;
      wxo_reg <= wxo_next;
      flags_reg.full_n <= full_n_next;
      flags_reg.half_full_n <= hf_n_next;
      flags_reg.almost_full_n <= af_n_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr_reg <= '0;
      rd_gray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
      rd_tok_reg <= 1'b0;
      rxo_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_data_reg <= 18'h00000;
      flags_reg.empty_n <= 1'b0;
      flags_reg.almost_empty_n <= 1'b0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
      rd_gray_reg <= to_gray(rd_ptr_next);
      wg_s1_reg <= wr_gray_reg;
      wg_s2_reg <= wg_s1_reg;
      rd_tok_reg <= rd_tok_next;
      rxo_reg <= rxo_next;
      oe_reg <= oe_next;
      rd_data_reg <= rd_data_next;
      flags_reg.empty_n <= empty_n_next;
      flags_reg.almost_empty_n <= ae_n_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
  assign RD_DATA = rd_data_reg;
  assign RD_DATA_OE = oe_reg;
  assign EMPTY_N = flags_reg.empty_n;
  assign FULL_N = flags_reg.full_n;
  assign HALF_FULL_N = flags_reg.half_full_n;
  assign ALMOST_EMPTY_N = flags_reg.almost_empty_n;
  assign ALMOST_FULL_N = flags_reg.almost_full_n;
  assign WR_CHAIN_OUT = wxo_reg;
  assign RD_CHAIN_OUT = rxo_reg;

endmodule : dcf_fifo

// >>> dcf_fifo_chk.sv
`timescale 1ns/100ps
module dcf_fifo_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WR_CLK_PIN,
  input wire logic RD_CLK_PIN,
  input wire logic OUT_EN_N,
  input wire logic [17:0] RD_DATA,
  input wire logic RD_DATA_OE,
  input wire logic EMPTY_N,
  input wire logic FULL_N,
  input wire logic HALF_FULL_N,
  input wire logic ALMOST_FULL_N
);
  // ages saturate so an old strobe never excuses a late change
  logic [3:0] wa_reg, ra_reg, oa_reg, wa_next, ra_next, oa_next;
  logic wp_reg, rp_reg;
  always_comb begin
    wa_next = (&wa_reg) ? wa_reg : wa_reg + 4'h1;
    ra_next = (&ra_reg) ? ra_reg : ra_reg + 4'h1;
    oa_next = (&oa_reg) ? oa_reg : oa_reg + 4'h1;
    if (WR_CLK_PIN && !wp_reg) wa_next = 4'h0;
    if (RD_CLK_PIN && !rp_reg) ra_next = 4'h0;
    if (!OUT_EN_N) oa_next = 4'h0;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {wa_reg, ra_reg, oa_reg} <= {4'hF, 4'hF, 4'h0};
      {wp_reg, rp_reg} <= 2'h3;
    end else begin
      {wa_reg, ra_reg, oa_reg} <= {wa_next, ra_next, oa_next};
      {wp_reg, rp_reg} <= {WR_CLK_PIN, RD_CLK_PIN};
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_timing_a: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
    else $error("ack late");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  full_half_a: assert property (!FULL_N |-> !HALF_FULL_N)
    else $error("full without half");
  full_almost_a: assert property (!FULL_N |-> !ALMOST_FULL_N)
    else $error("full without almost full");
  full_cause_a: assert property ($fell(FULL_N) |-> wa_reg <= 4'h8)
    else $error("full flag with no write");
  empty_cause_a: assert property ($fell(EMPTY_N) |-> ra_reg <= 4'h8)
    else $error("empty flag with no read");
  rd_change_a: assert property ($changed(RD_DATA) |-> ra_reg <= 4'h8)
    else $error("read data moved with no read");
  oe_off_a: assert property (oa_reg == 4'hF |-> !RD_DATA_OE)
    else $error("drive on while disabled");
  cover property ($fell(FULL_N));
  cover property ($fell(EMPTY_N));
  cover property ($changed(RD_DATA));
  cover property (WB_ACK_O);
endmodule : dcf_fifo_chk

// >>> dcf_params.svh
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

`define DCF_WIDTH 18
`define DCF_DEPTH_DEFAULT 8192

// wishbone register byte offsets
`define DCF_ADR_AE_OFF 8'h00
`define DCF_ADR_AF_OFF 8'h04
`define DCF_ADR_STATUS 8'h08
`define DCF_ADR_COUNT 8'h0C
`define DCF_ADR_CONFIG 8'h10

// status register bit positions
`define DCF_ST_EMPTY_N 0
`define DCF_ST_FULL_N 1
`define DCF_ST_HALF_N 2
`define DCF_ST_AE_N 3
`define DCF_ST_AF_N 4
`define DCF_ST_WR_TOK 5
`define DCF_ST_RD_TOK 6

// config register bit positions
`define DCF_CFG_CASCADE 0

`define DCF_AE_RESET 16'h007F
`define DCF_AF_RESET 16'h007F
`define DCF_CFG_RESET 1'h0

// cycles after reset release before the chain strap is trusted
`define DCF_INIT_CYCLES 3'h4

// positions in the synchronised pin vector
`define DCF_P_WCLK 0
`define DCF_P_RCLK 1
`define DCF_P_WEN 2
`define DCF_P_REN 3
`define DCF_P_OE 4
`define DCF_P_RT 5
`define DCF_P_FL 6
`define DCF_P_WXI 7
`define DCF_P_RXI 8
`define DCF_P_D 9
`define DCF_PINS 27
// enables idle high so nothing happens while the pipeline fills
`define DCF_PIN_RESET 27'h000001C

`endif

// >>> dcf_peer.sv
`timescale 1ns/100ps
module dcf_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic joined,
  output logic wr_pin,
  output logic rd_pin,
  output logic slot
);
  // period 16; apart, the read pin rises 4 cycles ahead of the write pin
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign wr_pin = cnt_reg[3];
  assign rd_pin = joined ? cnt_reg[3] : cnt_reg[3] ^ cnt_reg[2];
  assign slot = cnt_reg == 4'hE;
endmodule : dcf_peer

// >>> dcf_pin_sync.sv
`timescale 1ns/100ps
module dcf_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level,
  output logic [W-1:0] change
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;
  logic [W-1:0] agree;

  // s1 is only ever read by s2
  assign agree = ~(s2_reg ^ s3_reg);

  always_comb begin
    level_next = (level_reg & ~agree) | (s3_reg & agree);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level_reg <= RESET_VAL;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
  assign change = agree & (s3_reg ^ level_reg);

endmodule : dcf_pin_sync

// >>> dcf_pkg.sv
package dcf_pkg;

  typedef logic [17:0] dcf_word_t;

  typedef struct packed {
    logic almost_full_n;
    logic almost_empty_n;
    logic half_full_n;
    logic full_n;
    logic empty_n;
  } dcf_flags_s;

endpackage : dcf_pkg

// >>> test_dual_clock_deep_fifo.sv
`timescale 1ns/100ps
module test_dual_clock_deep_fifo;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, joined = 1'b0;
  logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
  logic WB_ACK_O, WR_CLK_PIN, RD_CLK_PIN, RD_DATA_OE, slot;
  logic WR_EN_N = 1'b1, RD_EN_N = 1'b1, OUT_EN_N = 1'b0;
  logic REPLAY_STROBE = 1'b0;
  logic [17:0] WR_DATA = 18'h0, RD_DATA;
  logic EMPTY_N, FULL_N, HALF_FULL_N, ALMOST_EMPTY_N, ALMOST_FULL_N;
  logic FIRST_IN_CHAIN = 1'b0;
  logic WR_CHAIN_IN = 1'b0, RD_CHAIN_IN = 1'b0, WR_CHAIN_OUT, RD_CHAIN_OUT;
  int bad_count = 0, samples_checked = 0, wi = 0, ri = 0, cyc = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  dcf_peer peer_u (.clk(SYS_CLK), .rst_n(RST_N), .joined,
    .wr_pin(WR_CLK_PIN), .rd_pin(RD_CLK_PIN), .slot);
  dcf_fifo #(.DEPTH(16)) dut_u (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
    .WR_CLK_PIN, .WR_EN_N, .WR_DATA, .RD_CLK_PIN, .RD_EN_N, .OUT_EN_N,
    .RD_DATA, .RD_DATA_OE, .REPLAY_STROBE, .EMPTY_N, .FULL_N, .HALF_FULL_N,
    .ALMOST_EMPTY_N, .ALMOST_FULL_N, .FIRST_IN_CHAIN, .WR_CHAIN_IN,
    .RD_CHAIN_IN, .WR_CHAIN_OUT, .RD_CHAIN_OUT);
  function automatic logic [17:0] pat(input int i);
    return 18'h2A5A5 ^ (18'(i) * 18'h14D);
  endfunction : pat
  function automatic logic [31:0] fl();
    return {27'h0, EMPTY_N, FULL_N, HALF_FULL_N, ALMOST_EMPTY_N,
      ALMOST_FULL_N};
  endfunction : fl
  task automatic chk(input logic [31:0] e, g, input string s);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 40);
    q = WB_DAT_O;
    if (n >= 40) bad_count++;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wb
  task automatic rdreg(input logic [7:0] a, input logic [31:0] e,
    input string s);
    wb(1'b0, a, 32'h0);
    chk(e, q, s);
  endtask : rdreg
  // one word per pin period; a read is judged at the following slot
  task automatic run(input int nw, input int nr);
    logic [17:0] e;
    for (int i = 0; i <= ((nw > nr) ? nw : nr); i++) begin
      @(posedge SYS_CLK iff slot);
      if (i > 0 && i <= nr) begin
        e = (ri < wi) ? pat(ri) : pat(ri - 1);
        ri = (ri < wi) ? ri + 1 : ri;
        chk(32'(e), 32'(RD_DATA), "rd_data");
      end
      wi = (i > 0 && i <= nw) ? wi + 1 : wi;
      WR_EN_N <= (i < nw) ? 1'b0 : 1'b1;
      RD_EN_N <= (i < nr) ? 1'b0 : 1'b1;
      WR_DATA <= pat(wi);
    end
  endtask : run
  task automatic t_regs;
    rdreg(8'h00, 32'h7F, "ae_off");
    rdreg(8'h04, 32'h7F, "af_off");
    rdreg(8'h10, 32'h0, "config");
    wb(1'b1, 8'h20, 32'h5A);
    rdreg(8'h20, 32'h0, "unmapped");
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h04, 32'h2);
    rdreg(8'h00, 32'h2, "ae_off");
    $display("test regs done");
  endtask : t_regs
  task automatic t_replay;
    run(3, 0);
    run(0, 3);
    REPLAY_STROBE <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    REPLAY_STROBE <= 1'b0;
    ri = 0;
    run(0, 3);
    $display("test replay done");
  endtask : t_replay
  task automatic t_both;
    @(posedge SYS_CLK iff slot);
    repeat (2) @(posedge SYS_CLK);
    joined <= 1'b1;
    run(4, 0);
    run(4, 4);
    repeat (8) @(posedge SYS_CLK);
    rdreg(8'h0C, 32'h4, "count");
    run(0, 4);
    $display("test joined done");
  endtask : t_both
  task automatic t_full;
    run(17, 0);
    wi = wi - 1;
    chk(32'h12, fl(), "full_flags");
    rdreg(8'h0C, 32'h10, "count");
    run(0, 17);
    chk(32'h0D, fl(), "empty_flags");
    $display("test full done");
  endtask : t_full
  // one device closing its own ring: each chain output is fed straight back
  task automatic t_chain;
    wb(1'b1, 8'h10, 32'h1);
    run(6, 0);
    wi = wi - 1;
    chk(32'h1, 32'(WR_CHAIN_OUT), "wr_chain_out");
    rdreg(8'h08, 32'h5F, "status");
    rdreg(8'h0C, 32'h5, "count");
    WR_CHAIN_IN <= WR_CHAIN_OUT;
    run(1, 5);
    chk(32'h1, 32'(RD_CHAIN_OUT), "rd_chain_out");
    rdreg(8'h08, 32'h37, "status");
    RD_CHAIN_IN <= RD_CHAIN_OUT;
    run(0, 1);
    wb(1'b1, 8'h10, 32'h0);
    $display("test chain done");
  endtask : t_chain
  task automatic t_oe;
    OUT_EN_N <= 1'b1;
    repeat (20) @(posedge SYS_CLK);
    chk(32'h0, 32'(RD_DATA_OE), "oe");
    OUT_EN_N <= 1'b0;
    repeat (8) @(posedge SYS_CLK);
    chk(32'h1, 32'(RD_DATA_OE), "oe");
    $display("test oe done");
  endtask : t_oe
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (20) @(posedge SYS_CLK);
    chk(32'h0D, fl(), "rst_flags");
    RST_N <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    t_regs;
    t_replay;
    t_both;
    t_full;
    t_chain;
    t_oe;
    tally_and_finish;
  end
endmodule : test_dual_clock_deep_fifo
bind dcf_fifo dcf_fifo_chk chk_u (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
  .WB_ACK_O, .WB_DAT_O, .WR_CLK_PIN, .RD_CLK_PIN, .OUT_EN_N, .RD_DATA,
  .RD_DATA_OE, .EMPTY_N, .FULL_N, .HALF_FULL_N, .ALMOST_FULL_N);
